// ### llpf_agen.sv
// llpf_agen: effective address adder with sign-extended offset
// assumes: offset already right-justified, pure combinational use
`timescale 1ns/1ps
module llpf_agen #(
    parameter int OFS_W = 16
) (
    // operands
    input wire logic [31:0] base,
    input wire logic [OFS_W-1:0] offset,
    // result
    output logic [31:0] eaddr
);
    // sign-extend then add, wrapping at 32 bits like the core adder
    always_comb
    begin
        eaddr = base + {{(32-OFS_W){offset[OFS_W-1]}}, offset};
    end
endmodule : llpf_agen

// ### llpf_mem_model.sv
// llpf_mem_model: cache and bus side, accepts requests, returns reads
// assumes: one request outstanding, slow adds two wait states
`timescale 1ns/1ps
module llpf_mem_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // request side
    input wire logic mem_valid,
    input wire llpf_pkg::llpf_mem_t mem_req,
    input wire logic slow,
    output logic mem_ready,
    // read return
    output logic rd_valid,
    output logic [31:0] rd_data
);
    // ------------------------------------------------------------
    // accept after wait states, plain reads come back two cycles on
    // ------------------------------------------------------------
    logic [1:0] wt, ret;
    logic [31:0] ra;
    // idle data toggles so a stale word never looks valid
    always @(posedge clk_sys)
    begin
        rd_valid <= 1'b0;
        rd_data <= ~rd_data;
        if (sys_rst)
        begin
            mem_ready <= 1'b0;
            wt <= 2'h0;
            ret <= 2'h0;
        end
        else
        begin
            if (mem_ready)
            begin
                mem_ready <= 1'b0;
                wt <= slow ? 2'h2 : 2'h0;
                if (!mem_req.write && !mem_req.prefetch)
                    ret <= 2'h2;
                ra <= mem_req.paddr;
            end
            else if (mem_valid && wt == 2'h0)
                mem_ready <= 1'b1;
            else if (mem_valid)
                wt <= wt - 2'h1;
            if (ret != 2'h0)
                ret <= ret - 2'h1;
            if (ret == 2'h1)
            begin
                rd_valid <= 1'b1;
                rd_data <= {ra[15:0], ra[31:16]} ^ 32'h3c5a0000;
            end
        end
    end
endmodule : llpf_mem_model

// ### llpf_pkg.sv
// llpf_pkg: shared types and constants for the linked load / prefetch unit
// assumes: one core clock, pipeline issues one operation at a time
package llpf_pkg;

    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int LL_OFS_W = 9;
    localparam int PF_OFS_W = 16;
    localparam int HINT_W = 5;
    localparam int ALIGN_LSB = 0;
    localparam int ALIGN_MSB = 1;
    localparam logic RES_FLAG_RST = 1'b0;

    // ------------------------------------------------------------
    // hint encodings
    // ------------------------------------------------------------
    localparam logic [4:0] HINT_LOAD = 5'h00;
    localparam logic [4:0] HINT_STORE = 5'h01;
    localparam logic [4:0] HINT_LOAD_STRM = 5'h04;
    localparam logic [4:0] HINT_STORE_STRM = 5'h05;
    localparam logic [4:0] HINT_LOAD_RETN = 5'h06;
    localparam logic [4:0] HINT_STORE_RETN = 5'h07;
    localparam logic [4:0] HINT_UNIMPL_LO = 5'h18;
    localparam logic [4:0] HINT_NOBUS = 5'h19;

    // pipeline operation codes
    typedef enum logic [2:0]
    {
        LLPF_OP_NONE = 3'b000,
        LLPF_OP_LINKED = 3'b001,
        LLPF_OP_COND = 3'b010,
        LLPF_OP_CACHE_PREFETCH_OP = 3'b011,
        LLPF_OP_EXCEPTION_RETURN_OP = 3'b100
    } llpf_op_t;

    // placement class handed to the cache with a prefetch
    typedef enum logic [1:0]
    {
        LLPF_PL_NORMAL = 2'b00,
        LLPF_PL_STREAM = 2'b01,
        LLPF_PL_RETAIN = 2'b10
    } llpf_place_t;

    // request from the pipeline
    typedef struct packed
    {
        llpf_op_t op;
        logic [31:0] base;
        logic [15:0] offset;
        logic [4:0] hint;
        logic [4:0] rt;
        logic [31:0] wdata;
    } llpf_req_t;

    // translation answer for the current address, from the mmu
    typedef struct packed
    {
        logic [31:0] paddr;
        logic [2:0] cca;
        logic fault;
        logic uncached;
    } llpf_xlat_t;

    // memory request to cache / bus
    typedef struct packed
    {
        logic [31:0] paddr;
        logic [2:0] cca;
        logic write;
        logic excl;
        logic prefetch;
        llpf_place_t place;
        logic [31:0] wdata;
    } llpf_mem_t;

endpackage : llpf_pkg

// ### llpf_unit.sv
// llpf_unit: linked word load, conditional store and cache prefetch
// assumes: translation answers combinationally for the issued address,
// memory accepts a request in the cycle mem_ready is high
`timescale 1ns/1ps
module llpf_unit (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // pipeline request
    input wire logic req_valid,
    input wire llpf_pkg::llpf_req_t req,
    output logic req_ready,
    // translation lookup
    output logic [31:0] xlat_vaddr,
    input wire llpf_pkg::llpf_xlat_t xlat,
    // memory side
    output logic mem_valid,
    output llpf_pkg::llpf_mem_t mem_req,
    input wire logic mem_ready,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    // register writeback
    output logic wb_valid,
    output logic [4:0] wb_rt,
    output logic [31:0] wb_data,
    // exceptions and status
    output logic exc_addr_err,
    output logic exc_reserved_opcode_trap,
    output logic reservation_flag
);

    // ------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LLPF_IDLE = 2'b00,
        LLPF_ISSUE = 2'b01,
        LLPF_WAIT = 2'b10
    } llpf_state_t;

    llpf_state_t state_r, state_nxt;
    llpf_pkg::llpf_mem_t mem_r, mem_nxt;
    logic mem_valid_r, mem_valid_nxt;
    logic res_r, res_nxt;
    logic [4:0] rt_r, rt_nxt;
    logic is_cond_r, is_cond_nxt;
    logic wb_valid_r, wb_valid_nxt;
    logic [4:0] wb_rt_r, wb_rt_nxt;
    logic [31:0] wb_data_r, wb_data_nxt;
    logic aerr_r, aerr_nxt;
    logic ri_r, ri_nxt;
    logic ready_r, ready_nxt;
    logic [31:0] ea_ll, ea_pf, ea_sel;

    // reserved-hint test used by the prefetch decision
    function automatic logic hint_reserved(input logic [4:0] h);
        hint_reserved = (h == 5'h02) || (h == 5'h03) ||
            ((h >= 5'h08) && (h < llpf_pkg::HINT_UNIMPL_LO));
    endfunction : hint_reserved

    // placement class for a given hint
    function automatic llpf_pkg::llpf_place_t hint_place(input logic [4:0] h);
        case (h)
            llpf_pkg::HINT_LOAD_STRM, llpf_pkg::HINT_STORE_STRM:
                hint_place = llpf_pkg::LLPF_PL_STREAM;
            llpf_pkg::HINT_LOAD_RETN, llpf_pkg::HINT_STORE_RETN:
                hint_place = llpf_pkg::LLPF_PL_RETAIN;
            default:
                hint_place = llpf_pkg::LLPF_PL_NORMAL;
        endcase
    endfunction : hint_place

    // store-intent hints: odd codes among 0..7
    function automatic logic hint_store(input logic [4:0] h);
        hint_store = (h[4:3] == 2'b00) && h[0];
    endfunction : hint_store

    // ------------------------------------------------------------
    // address generation
    // ------------------------------------------------------------
    llpf_agen #(.OFS_W(llpf_pkg::LL_OFS_W)) u_agen_ll (
        .base(req.base),
        .offset(req.offset[llpf_pkg::LL_OFS_W-1:0]),
        .eaddr(ea_ll)
    );

    llpf_agen #(.OFS_W(llpf_pkg::PF_OFS_W)) u_agen_pf (
        .base(req.base),
        .offset(req.offset),
        .eaddr(ea_pf)
    );

    // conditional store shares the 16-bit form with prefetch
    assign ea_sel = (req.op == llpf_pkg::LLPF_OP_LINKED) ? ea_ll : ea_pf;
    assign xlat_vaddr = ea_sel;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        mem_nxt = mem_r;
        mem_valid_nxt = mem_valid_r;
        res_nxt = res_r;
        rt_nxt = rt_r;
        is_cond_nxt = is_cond_r;
        wb_valid_nxt = 1'b0;
        wb_rt_nxt = wb_rt_r;
        wb_data_nxt = wb_data_r;
        aerr_nxt = 1'b0;
        ri_nxt = 1'b0;
        case (state_r)
            LLPF_IDLE:
            begin
                if (req_valid)
                begin
                    mem_nxt.paddr = xlat.paddr;
                    mem_nxt.cca = xlat.cca;
                    mem_nxt.wdata = req.wdata;
                    mem_nxt.excl = 1'b0;
                    mem_nxt.prefetch = 1'b0;
                    mem_nxt.write = 1'b0;
                    mem_nxt.place = llpf_pkg::LLPF_PL_NORMAL;
                    rt_nxt = req.rt;
                    case (req.op)
                        llpf_pkg::LLPF_OP_LINKED:
                        begin
                            if (ea_ll[llpf_pkg::ALIGN_MSB:llpf_pkg::ALIGN_LSB]
                                != 2'b00)
                            begin
                                aerr_nxt = 1'b1;
                            end
                            else
                            begin
                                // shared read only: never steal the line
                                mem_nxt.excl = 1'b0;
                                mem_valid_nxt = 1'b1;
                                is_cond_nxt = 1'b0;
                                res_nxt = 1'b1;
                                state_nxt = LLPF_ISSUE;
                            end
                        end
                        llpf_pkg::LLPF_OP_COND:
                        begin
                            if (ea_pf[llpf_pkg::ALIGN_MSB:llpf_pkg::ALIGN_LSB]
                                != 2'b00)
                            begin
                                aerr_nxt = 1'b1;
                            end
                            else if (res_r)
                            begin
                                mem_nxt.write = 1'b1;
                                mem_valid_nxt = 1'b1;
                                is_cond_nxt = 1'b1;
                                res_nxt = 1'b0;
                                state_nxt = LLPF_ISSUE;
                            end
                            else
                            begin
                                wb_valid_nxt = 1'b1;
                                wb_rt_nxt = req.rt;
                                wb_data_nxt = 32'h0000_0000;
                            end
                        end
                        llpf_pkg::LLPF_OP_CACHE_PREFETCH_OP:
                        begin
                            if (req.hint >= llpf_pkg::HINT_UNIMPL_LO &&
                                req.hint != llpf_pkg::HINT_NOBUS)
                            begin
                                ri_nxt = 1'b1;
                            end
                            else if (req.hint == llpf_pkg::HINT_NOBUS)
                            begin
                                // completes quietly, nothing issued
                                ri_nxt = 1'b0;
                            end
                            else if (hint_reserved(req.hint) || xlat.fault ||
                                xlat.uncached)
                            begin
                                // faults swallowed, no data moves
                                mem_valid_nxt = 1'b0;
                            end
                            else
                            begin
                                // fire and forget: pipeline is held only until memory accepts
                                mem_nxt.prefetch = 1'b1;
                                mem_nxt.excl = hint_store(req.hint);
                                mem_nxt.place = hint_place(req.hint);
                                mem_valid_nxt = 1'b1;
                                state_nxt = LLPF_ISSUE;
                            end
                        end
                        llpf_pkg::LLPF_OP_EXCEPTION_RETURN_OP:
                        begin
                            res_nxt = 1'b0;
                        end
                        default:
                        begin
                            state_nxt = LLPF_IDLE;
                        end
                    endcase
                end
            end
            LLPF_ISSUE:
            begin
                if (mem_ready)
                begin
                    mem_valid_nxt = 1'b0;
                    if (mem_r.prefetch)
                    begin
                        // no return data awaited for a prefetch
                        state_nxt = LLPF_IDLE;
                    end
                    else if (is_cond_r)
                    begin
                        wb_valid_nxt = 1'b1;
                        wb_rt_nxt = rt_r;
                        wb_data_nxt = 32'h0000_0001;
                        state_nxt = LLPF_IDLE;
                    end
                    else
                    begin
                        state_nxt = LLPF_WAIT;
                    end
                end
            end
            LLPF_WAIT:
            begin
                if (rd_valid)
                begin
                    wb_valid_nxt = 1'b1;
                    wb_rt_nxt = rt_r;
                    wb_data_nxt = rd_data;
                    state_nxt = LLPF_IDLE;
                end
                // an exception return seen while waiting clears the reservation
                if (req_valid && req.op == llpf_pkg::LLPF_OP_EXCEPTION_RETURN_OP)
                begin
                    res_nxt = 1'b0;
                end
            end
            default:
            begin
                state_nxt = LLPF_IDLE;
            end
        endcase
        // ready is registered so the pipeline sees a flop, not a decode
        ready_nxt = (state_nxt == LLPF_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_r <= LLPF_IDLE;
            mem_r <= '0;
            mem_valid_r <= 1'b0;
            res_r <= llpf_pkg::RES_FLAG_RST;
            rt_r <= 5'h00;
            is_cond_r <= 1'b0;
            wb_valid_r <= 1'b0;
            wb_rt_r <= 5'h00;
            wb_data_r <= 32'h0000_0000;
            aerr_r <= 1'b0;
            ri_r <= 1'b0;
            ready_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            mem_r <= mem_nxt;
            mem_valid_r <= mem_valid_nxt;
            res_r <= res_nxt;
            rt_r <= rt_nxt;
            is_cond_r <= is_cond_nxt;
            wb_valid_r <= wb_valid_nxt;
            wb_rt_r <= wb_rt_nxt;
            wb_data_r <= wb_data_nxt;
            aerr_r <= aerr_nxt;
            ri_r <= ri_nxt;
            ready_r <= ready_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // accept only when idle; exception_return_op is also seen in wait
    assign req_ready = ready_r;
    assign mem_valid = mem_valid_r;
    assign mem_req = mem_r;
    assign wb_valid = wb_valid_r;
    assign wb_rt = wb_rt_r;
    assign wb_data = wb_data_r;
    assign exc_addr_err = aerr_r;
    assign exc_reserved_opcode_trap = ri_r;
    assign reservation_flag = res_r;

endmodule : llpf_unit

// ### llpf_unit_checker.sv
// llpf_unit_checker: port-level assertions for the linked load unit
// assumes: bound onto llpf_unit, translation answers in the same cycle
`timescale 1ns/1ps
module llpf_unit_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // pipeline and translation
    input wire logic req_valid,
    input wire llpf_pkg::llpf_req_t req,
    input wire logic req_ready,
    input wire logic [31:0] xlat_vaddr,
    input wire llpf_pkg::llpf_xlat_t xlat,
    // memory side and results
    input wire logic mem_valid,
    input wire llpf_pkg::llpf_mem_t mem_req,
    input wire logic mem_ready,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data,
    input wire logic wb_valid,
    input wire logic [4:0] wb_rt,
    input wire logic [31:0] wb_data,
    input wire logic exc_addr_err,
    input wire logic exc_reserved_opcode_trap,
    input wire logic reservation_flag
);
    // ------------------------------------------------------------
    // shorthand and step sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic tk, al, go;
    logic [4:0] h, h_q;
    assign tk = req_valid && req_ready;
    assign al = (xlat_vaddr[1:0] == 2'b00);
    assign h = req.hint;
    // only load/store hints on a cached, mapped page reach the bus
    assign go = (h < 5'h08) && (h[4:1] != 4'h1) && !xlat.fault
        && !xlat.uncached;
    // hint of the previous cycle, for checking what was launched
    always_ff @(posedge clk_sys)
        h_q <= h;
    sequence ll_take;
        tk && req.op == llpf_pkg::LLPF_OP_LINKED;
    endsequence
    sequence pf_take;
        tk && req.op == llpf_pkg::LLPF_OP_CACHE_PREFETCH_OP;
    endsequence
    sequence sc_take;
        tk && req.op == llpf_pkg::LLPF_OP_COND && al;
    endsequence
    ll_addr_a: assert property (ll_take |-> xlat_vaddr ==
        req.base + {{23{req.offset[8]}}, req.offset[8:0]})
        else $error("linked load address wrong");
    ll_issue_a: assert property (ll_take ##0 al |=> mem_valid
        && reservation_flag && !mem_req.excl && !mem_req.write
        && mem_req.paddr == $past(xlat.paddr))
        else $error("linked load request wrong");
    ll_misalign_a: assert property (ll_take ##0 !al |=>
        exc_addr_err && !mem_valid) else $error("misaligned load not trapped");
    ll_return_a: assert property (rd_valid |=> wb_valid
        && wb_data == $past(rd_data)) else $error("load data not written");
    pf_addr_a: assert property (pf_take |-> xlat_vaddr ==
        req.base + {{16{req.offset[15]}}, req.offset})
        else $error("prefetch address wrong");
    pf_nop_a: assert property (pf_take ##0 !go |=>
        !mem_valid && !exc_addr_err) else $error("prefetch nop moved data");
    pf_trap_a: assert property (pf_take ##0 h >= 5'h18 |=>
        exc_reserved_opcode_trap == (h_q != 5'h19))
        else $error("prefetch trap wrong");
    pf_launch_a: assert property (pf_take ##0 go |=> mem_valid
        && mem_req.prefetch && !mem_req.write && mem_req.excl == h_q[0]
        && mem_req.cca == $past(xlat.cca) && mem_req.place == (h_q[2] ?
        (h_q[1] ? llpf_pkg::LLPF_PL_RETAIN : llpf_pkg::LLPF_PL_STREAM)
        : llpf_pkg::LLPF_PL_NORMAL)) else $error("prefetch request wrong");
    pf_nostall_a: assert property (mem_valid && mem_ready
        && mem_req.prefetch |=> req_ready) else $error("prefetch stalled");
    exception_return_op_clear_a: assert property (req_valid &&
        req.op == llpf_pkg::LLPF_OP_EXCEPTION_RETURN_OP |=> !reservation_flag)
        else $error("exception return kept reservation");
    sc_fail_a: assert property (sc_take ##0 !reservation_flag |=>
        wb_valid && wb_data == 32'h0 && !mem_valid)
        else $error("failed store wrong");
    sc_pass_a: assert property (sc_take ##0 reservation_flag |=>
        mem_valid && mem_req.write && mem_req.wdata == $past(req.wdata)
        ##[0:40] wb_valid && wb_data == 32'h1)
        else $error("successful store wrong");
endmodule : llpf_unit_checker

// ### llpf_unit_tb_top.sv
// llpf_unit_tb_top: random and corner tests of the linked load unit
// assumes: memory model answers, translation echoes the address
`timescale 1ns/1ps
module llpf_unit_tb_top;
    // ------------------------------------------------------------
    // signals, design, partner and monitor
    // ------------------------------------------------------------
    logic clk_sys, sys_rst, req_valid, req_ready, mem_valid, mem_ready;
    logic rd_valid, wb_valid, exc_addr_err, exc_reserved_opcode_trap;
    logic reservation_flag, slow, flt, unc;
    logic [31:0] xlat_vaddr, rd_data, wb_data, wb_last, b, ea;
    logic [15:0] o;
    logic [4:0] wb_rt, h, rt_last;
    logic [2:0] cca;
    llpf_pkg::llpf_req_t req;
    llpf_pkg::llpf_xlat_t xlat;
    llpf_pkg::llpf_mem_t mem_req;
    int n_fail, compares, n_pf, n_trap, n_ae, n_wb, k, p, t, a, w;
    assign xlat = '{paddr: xlat_vaddr, cca: cca, fault: flt, uncached: unc};
    llpf_unit uut (.clk_sys, .sys_rst, .req_valid, .req, .req_ready,
        .xlat_vaddr, .xlat, .mem_valid, .mem_req, .mem_ready, .rd_valid,
        .rd_data, .wb_valid, .wb_rt, .wb_data, .exc_addr_err,
        .exc_reserved_opcode_trap, .reservation_flag);
    llpf_mem_model mem (.clk_sys, .sys_rst, .mem_valid, .mem_req, .slow,
        .mem_ready, .rd_valid, .rd_data);
    // clock at 8 ns
    initial
    begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // count one-cycle pulses so no check depends on exact timing
    always @(posedge clk_sys)
    begin
        if (mem_valid && mem_ready && mem_req.prefetch) n_pf++;
        if (exc_reserved_opcode_trap) n_trap++;
        if (exc_addr_err) n_ae++;
        if (wb_valid) n_wb++;
        if (wb_valid) wb_last = wb_data;
        if (wb_valid) rt_last = wb_rt;
    end
    function automatic logic [31:0] rdv(input logic [31:0] x);
        return {x[15:0], x[31:16]} ^ 32'h3c5a0000;
    endfunction : rdv
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic conclude();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // request held until the edge that takes it
    task automatic issue(input llpf_pkg::llpf_op_t op,
        input logic [31:0] bb, input logic [15:0] oo, input logic [4:0] hh);
        int i;
        req = '{op: op, base: bb, offset: oo, hint: hh, rt: 5'h0b, wdata: bb};
        req_valid = 1'b1;
        for (i = 0; i < 60 && req_ready !== 1'b1; i++)
            @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
        req_valid = 1'b0;
        for (i = 0; i < 60 && req_ready !== 1'b1; i++)
            @(posedge clk_sys) #1;
        // a unit that never frees up counts as a mismatch
        chk("ready timeout", req_ready, 1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : issue
    task automatic run(input llpf_pkg::llpf_op_t op);
        issue(op, 32'h00001000, 16'h0, 5'h0);
    endtask : run
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h7f73));
        {sys_rst, req_valid, req, slow, flt, unc, cca} = '0;
        sys_rst = 1'b1;
        repeat (12) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        chk("flag after reset", reservation_flag, 1'b0);
        for (k = 0; k < 24; k++)
        begin
            b = $urandom;
            o = 16'($urandom);
            slow = 1'($urandom);
            cca = 3'($urandom);
            ea = b + {{23{o[8]}}, o[8:0]};
            a = n_ae;
            w = n_wb;
            issue(llpf_pkg::LLPF_OP_LINKED, b, o, 5'h0);
            if (ea[1:0] == 2'b00)
                chk("ll data", wb_last, rdv(ea));
            else
                chk("ll align", n_ae - a, n_wb - w + 1);
        end
        run(llpf_pkg::LLPF_OP_EXCEPTION_RETURN_OP);
        run(llpf_pkg::LLPF_OP_COND);
        chk("sc no link", wb_last, 32'h0);
        run(llpf_pkg::LLPF_OP_LINKED);
        run(llpf_pkg::LLPF_OP_LINKED);
        chk("flag", reservation_flag, 1'b1);
        chk("ll rt", rt_last, 5'h0b);
        run(llpf_pkg::LLPF_OP_COND);
        chk("sc linked", wb_last, 32'h1);
        chk("sc rt", rt_last, 5'h0b);
        run(llpf_pkg::LLPF_OP_COND);
        chk("sc second", wb_last, 32'h0);
        run(llpf_pkg::LLPF_OP_LINKED);
        run(llpf_pkg::LLPF_OP_EXCEPTION_RETURN_OP);
        run(llpf_pkg::LLPF_OP_COND);
        chk("sc after return", wb_last, 32'h0);
        run(llpf_pkg::LLPF_OP_LINKED);
        // the reservation is kept while prefetches run
        for (k = 0; k < 64; k++)
        begin
            h = k[4:0];
            flt = k > 31 && $urandom_range(3) == 0;
            unc = k > 31 && $urandom_range(3) == 0;
            slow = 1'($urandom);
            b = $urandom;
            o = 16'($urandom);
            {p, t, a} = {n_pf, n_trap, n_ae};
            issue(llpf_pkg::LLPF_OP_CACHE_PREFETCH_OP, b, o, h);
            chk("pf bus read", n_pf - p, h < 8 && h[4:1] != 1 && !flt && !unc);
            chk("pf trap", n_trap - t, h >= 24 && h != 25);
            chk("pf addr err", n_ae - a, 0);
        end
        conclude();
    end
    // cut a hang short
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end
endmodule : llpf_unit_tb_top
bind llpf_unit llpf_unit_checker chk_i (.clk_sys, .sys_rst, .req_valid,
    .req, .req_ready, .xlat_vaddr, .xlat, .mem_valid, .mem_req, .mem_ready,
    .rd_valid, .rd_data, .wb_valid, .wb_rt, .wb_data, .exc_addr_err,
    .exc_reserved_opcode_trap, .reservation_flag);
